// [hw/gei_pkg.sv]
// Constants shared by the pin and edge interrupt unit.
// Assumes a register port that carries 7-bit indices and 16-bit words.
package gei_pkg;

  // ----------------------------------------------------------------
  // Register indices
  // ----------------------------------------------------------------
  localparam logic [6:0] ADDR_PIN_DATA     = 7'h5A;
  localparam logic [6:0] ADDR_PIN_DIR      = 7'h5C;
  localparam logic [6:0] ADDR_RISE_EN      = 7'h5E;
  localparam logic [6:0] ADDR_FALL_EN      = 7'h60;
  localparam logic [6:0] ADDR_IRQ_STATUS   = 7'h62;

  // ----------------------------------------------------------------
  // Field layout and reset values
  // ----------------------------------------------------------------
  localparam int         NUM_PINS          = 10;
  localparam int         NUM_SRC           = 16;
  localparam int         BIT_OVERFLOW      = 15;
  localparam int         BIT_CLIP          = 14;
  localparam int         BIT_TOUCH_MX      = 13;
  localparam int         BIT_TOUCH_PX      = 12;
  localparam int         BIT_CONV_READY    = 11;
  localparam logic [15:0] PIN_MASK         = 16'h03FF;
  localparam logic [15:0] SRC_MASK         = 16'hFBFF;
  localparam logic [15:0] REG_RESET        = 16'h0000;
  localparam logic [15:0] READ_UNMAPPED    = 16'h0000;

endpackage : gei_pkg

// [hw/gei_edge_sync.sv]
// Three-stage synchroniser with settled level and edge pulses.
// Assumes every input bit is asynchronous to mclk.
`timescale 1ns/100ps
`default_nettype none

module gei_edge_sync #(
  parameter int WIDTH = 16
) (
  input  wire logic             mclk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] rise,
  output logic      [WIDTH-1:0] fall
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] stable;
    logic [WIDTH-1:0] rise;
    logic [WIDTH-1:0] fall;
  } gei_sync_t;

  gei_sync_t st_q;
  gei_sync_t st_d;

  if (WIDTH < 1)
  begin : g_bad_width
    $error("gei_edge_sync needs WIDTH of at least one");
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // A change is accepted only when stages two and three agree, which
  // filters a one-cycle glitch caught at the first stage.
  always_comb
  begin
    logic [WIDTH-1:0] agree;
    agree     = ~(st_q.s2 ^ st_q.s3);
    st_d      = st_q;
    st_d.s1   = async_in;
    st_d.s2   = st_q.s1;
    st_d.s3   = st_q.s2;
    st_d.stable = (agree & st_q.s3) | (~agree & st_q.stable);
    st_d.rise = agree & st_q.s3 & ~st_q.stable;
    st_d.fall = agree & ~st_q.s3 & st_q.stable;
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign level = st_q.stable;
  assign rise  = st_q.rise;
  assign fall  = st_q.fall;

endmodule : gei_edge_sync

`default_nettype wire

// [hw/gei_unit.sv]
// Ten general-purpose pins with edge-armed interrupt latching.
// Assumes an outer link layer that turns codec-link register frames into
// single-cycle read and write strobes with a 7-bit index.
`timescale 1ns/100ps
`default_nettype none

// Function
// [R1] Pin data read returns sensed level of all ten pins, any direction.
// [R2] Written data reaches a pin only while that pin is an output.
// [R3] Direction bit one makes the pin an output driving stored data.
// [R4] Direction bit zero makes the pin an input with driver released.
// [R5] Pin data register resets to zero.
// [R6] Direction register resets to zero, all pins inputs.
// [R7] Rising-edge enable register resets to zero.
// [R8] Falling-edge enable register resets to zero.
// [R9] Rise enable bits 15..11 arm internal sources; bit 10 reserved.
// [R10] Rise enable bits 9..0 arm low-to-high detection on pins.
// [R11] Fall enable bits 15..11 arm internal sources, same order.
// [R12] Fall enable bits 9..0 arm high-to-low detection on pins.
// [R13] Enabled edge latches status; host reads it, clears by writing one.
// [R14] Pin status cleared per bit by writing one; zero leaves it.
// [R15] Both enables catch either edge; interrupt output while any status set.
// [R16] Reserved bits read zero and ignore writes.
module gei_unit (
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic [6:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  output logic             reg_rvalid,
  input  wire logic [9:0]  pin_level_bits,
  output logic      [9:0]  pin_out,
  output logic      [9:0]  pin_oe_n,
  input  wire logic        overflow_source,
  input  wire logic        clip_source,
  input  wire logic        touch_minus_x_sense,
  input  wire logic        touch_plus_x_sense,
  input  wire logic        conv_ready_source,
  output logic             irq_output_pin
);

  typedef struct packed {
    logic [15:0] pin_data;
    logic [15:0] pin_direction;
    logic [15:0] rise_en;
    logic [15:0] fall_en;
    logic [15:0] status;
    logic [15:0] rdata;
    logic        rvalid;
    logic        irq;
  } gei_state_t;

  gei_state_t st_q;
  gei_state_t st_d;

  logic [gei_pkg::NUM_SRC-1:0] src_raw;
  logic [gei_pkg::NUM_SRC-1:0] src_level;
  logic [gei_pkg::NUM_SRC-1:0] src_rise;
  logic [gei_pkg::NUM_SRC-1:0] src_fall;

  // ----------------------------------------------------------------
  // Source synchronisation
  // ----------------------------------------------------------------
  // Internal sources are treated as asynchronous too, since the analog
  // comparators and converter run on their own timing.
  always_comb
  begin
    src_raw = '0;
    src_raw[gei_pkg::NUM_PINS-1:0]       = pin_level_bits;
    src_raw[gei_pkg::BIT_OVERFLOW]       = overflow_source;
    src_raw[gei_pkg::BIT_CLIP]           = clip_source;
    src_raw[gei_pkg::BIT_TOUCH_MX]       = touch_minus_x_sense;
    src_raw[gei_pkg::BIT_TOUCH_PX]       = touch_plus_x_sense;
    src_raw[gei_pkg::BIT_CONV_READY]     = conv_ready_source;
  end

  gei_edge_sync #(
    .WIDTH    (gei_pkg::NUM_SRC)
  ) u_sync (
    .mclk     (mclk),
    .sys_rst  (sys_rst),
    .async_in (src_raw),
    .level    (src_level),
    .rise     (src_rise),
    .fall     (src_fall)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic        hit_data;
    logic        hit_dir;
    logic        hit_rise;
    logic        hit_fall;
    logic        hit_stat;
    logic [15:0] events;
    logic [15:0] clr;
    events   = gei_pkg::REG_RESET;
    clr      = gei_pkg::REG_RESET;
    hit_data = reg_addr == gei_pkg::ADDR_PIN_DATA;
    hit_dir  = reg_addr == gei_pkg::ADDR_PIN_DIR;
    hit_rise = reg_addr == gei_pkg::ADDR_RISE_EN;
    hit_fall = reg_addr == gei_pkg::ADDR_FALL_EN;
    hit_stat = reg_addr == gei_pkg::ADDR_IRQ_STATUS;
    st_d = st_q;

    // Register writes; reserved bits never store.
    if (reg_wr && hit_data)
    begin
      st_d.pin_data = reg_wdata & gei_pkg::PIN_MASK; // [R2] [R16]
    end
    if (reg_wr && hit_dir)
    begin
      st_d.pin_direction = reg_wdata & gei_pkg::PIN_MASK; // [R3] [R4] [R16]
    end
    if (reg_wr && hit_rise)
    begin
      st_d.rise_en = reg_wdata & gei_pkg::SRC_MASK; // [R9] [R10] [R16]
    end
    if (reg_wr && hit_fall)
    begin
      st_d.fall_en = reg_wdata & gei_pkg::SRC_MASK; // [R11] [R12] [R16]
    end

    // An edge landing in the same cycle as its clear stays latched, so
    // a host that clears late never loses a fresh event.
    events = ((src_rise & st_q.rise_en) | (src_fall & st_q.fall_en))
             & gei_pkg::SRC_MASK; // [R9] [R10] [R11] [R12] [R15]
    clr    = (reg_wr && hit_stat) ? reg_wdata : gei_pkg::REG_RESET;
    st_d.status = (st_q.status & ~clr) | events; // [R13] [R14]
    st_d.irq    = |st_d.status; // [R15]

    // Reads answer one cycle after the strobe.
    st_d.rvalid = reg_rd;
    if (reg_rd)
    begin
      if (hit_data)
      begin
        st_d.rdata = src_level & gei_pkg::PIN_MASK; // [R1]
      end
      else if (hit_dir)
      begin
        st_d.rdata = st_q.pin_direction;
      end
      else if (hit_rise)
      begin
        st_d.rdata = st_q.rise_en;
      end
      else if (hit_fall)
      begin
        st_d.rdata = st_q.fall_en;
      end
      else if (hit_stat)
      begin
        st_d.rdata = st_q.status; // [R13]
      end
      else
      begin
        st_d.rdata = gei_pkg::READ_UNMAPPED;
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_q.pin_data      <= gei_pkg::REG_RESET; // [R5]
      st_q.pin_direction <= gei_pkg::REG_RESET; // [R6]
      st_q.rise_en       <= gei_pkg::REG_RESET; // [R7]
      st_q.fall_en       <= gei_pkg::REG_RESET; // [R8]
      st_q.status        <= gei_pkg::REG_RESET;
      st_q.rdata         <= gei_pkg::REG_RESET;
      st_q.rvalid        <= 1'b0;
      st_q.irq           <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Data is always presented; the enable alone decides whether it
  // reaches the pad, so switching direction never glitches old data.
  assign pin_out        = st_q.pin_data[gei_pkg::NUM_PINS-1:0]; // [R2] [R3]
  assign pin_oe_n       = ~st_q.pin_direction[gei_pkg::NUM_PINS-1:0]; // [R4]
  assign reg_rdata      = st_q.rdata;
  assign reg_rvalid     = st_q.rvalid;
  assign irq_output_pin = st_q.irq;

endmodule : gei_unit

`default_nettype wire

// [tb/gei_host.sv]
// Host model of the register port: one strobe per access.
// Assumes the unit samples strobes on the rising edge of mclk.
`timescale 1ns/100ps
`default_nettype none
module gei_host (
  input  wire logic        mclk,
  input  wire logic        reg_rvalid,
  output logic      [6:0]  reg_addr,
  output logic             reg_wr,
  output logic      [15:0] reg_wdata,
  output logic             reg_rd
);
  initial
  begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 7'h00;
    reg_wdata = 16'h0000;
  end
  // Released lines show the inverse, so stale values never match by luck.
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : wr
  task automatic rd(input logic [6:0] a, output logic ok);
    int n;
    n = 0;
    @(negedge mclk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge mclk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    while (reg_rvalid !== 1'b1 && n < 4)
    begin
      @(negedge mclk);
      n++;
    end
    ok = reg_rvalid;
  endtask : rd
endmodule : gei_host
`default_nettype wire

// [tb/gei_unit_monitor.sv]
// Port checker of the pin and edge interrupt unit.
// Assumes the register indices of gei_pkg.
`timescale 1ns/100ps
`default_nettype none
module gei_unit_monitor (
  input wire logic        mclk,
  input wire logic        sys_rst,
  input wire logic [6:0]  reg_addr,
  input wire logic        reg_wr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic        reg_rvalid,
  input wire logic [9:0]  pin_out,
  input wire logic [9:0]  pin_oe_n,
  input wire logic        irq_output_pin
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  wire clr = reg_wr && reg_addr == gei_pkg::ADDR_IRQ_STATUS;
  wire dir = reg_wr && reg_addr == gei_pkg::ADDR_PIN_DIR;
  AST_RVALID: assert property (reg_rvalid == $past(reg_rd))
    else $error("read answer not one cycle after strobe");
  AST_OUT_WR: assert property (reg_wr && reg_addr == gei_pkg::ADDR_PIN_DATA
    |=> pin_out == $past(reg_wdata[9:0])) else $error("pin data lost");
  AST_OE_WR: assert property (dir |=> pin_oe_n == ~$past(reg_wdata[9:0]))
    else $error("direction not applied");
  AST_OE_HOLD: assert property (!dir |=> $stable(pin_oe_n))
    else $error("direction changed without write");
  AST_RSV_PIN: assert property (reg_rd && reg_addr inside {7'h5A, 7'h5C}
    |=> reg_rdata[15:10] == 6'h00) else $error("reserved pin bits");
  AST_RSV_EN: assert property (reg_rd && reg_addr inside {7'h5E, 7'h60}
    |=> !reg_rdata[10]) else $error("reserved enable bit");
  AST_UNMAPPED: assert property (reg_rd && !(reg_addr inside {7'h5A,
    7'h5C, 7'h5E, 7'h60, 7'h62}) |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  AST_IRQ_HOLD: assert property (irq_output_pin && !clr |=> irq_output_pin)
    else $error("interrupt dropped without clear");
  AST_IRQ_FALL: assert property ($fell(irq_output_pin) |-> $past(clr)
    || $past(clr, 2)) else $error("interrupt fell without clear");
endmodule : gei_unit_monitor
bind gei_unit gei_unit_monitor mon (.mclk(mclk), .sys_rst(sys_rst),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .pin_out(pin_out), .pin_oe_n(pin_oe_n), .irq_output_pin(irq_output_pin));
`default_nettype wire

// [tb/tb.sv]
// Self-checking bench of the pin and edge interrupt unit.
// Assumes gei_host as the register master; ext drives pins and sources.
`timescale 1ns/100ps
`default_nettype none
module tb;
  typedef struct packed {logic [6:0] a; logic [15:0] w, r;} gei_row_t;
  logic        mclk, sys_rst, wr, rd, rv, irq;
  logic [6:0]  addr;
  logic [15:0] wd, rdat, ext, b;
  logic [9:0]  pout, oe_n, lvl;
  int          err_count, compares;
  gei_row_t    rows [6] = '{'{7'h5C, 16'hFFFF, 16'h03FF},
    '{7'h5E, 16'hFFFF, 16'hFBFF}, '{7'h60, 16'hFFFF, 16'hFBFF},
    '{7'h7E, 16'hFFFF, 16'h0000}, '{7'h5E, 16'h0000, 16'h0000},
    '{7'h60, 16'h0000, 16'h0000}};
  assign lvl = (oe_n & ext[9:0]) | (~oe_n & pout);
  gei_host host (.mclk(mclk), .reg_rvalid(rv), .reg_addr(addr), .reg_wr(wr),
    .reg_wdata(wd), .reg_rd(rd));
  gei_unit dut (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(addr), .reg_wr(wr),
    .reg_wdata(wd), .reg_rd(rd), .reg_rdata(rdat), .reg_rvalid(rv),
    .pin_level_bits(lvl), .pin_out(pout), .pin_oe_n(oe_n),
    .overflow_source(ext[15]), .clip_source(ext[14]),
    .touch_minus_x_sense(ext[13]), .touch_plus_x_sense(ext[12]),
    .conv_ready_source(ext[11]), .irq_output_pin(irq));
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic stop_test;
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : stop_test
  task automatic chk(input string n, input logic [15:0] e, g);
    compares++;
    if (g !== e)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic rdchk(input logic [6:0] a, input logic [15:0] e);
    logic ok;
    host.rd(a, ok);
    if (ok !== 1'b1)
    begin
      err_count++;
      stop_test();
    end
    else
      chk("reg_rdata", e, rdat);
  endtask : rdchk
  // Eight cycles cover the synchroniser and the status latch.
  task automatic flip(input logic [15:0] e);
    ext = ext ^ b;
    repeat (8) @(negedge mclk);
    rdchk(gei_pkg::ADDR_IRQ_STATUS, e);
    chk("irq", {15'h0000, |e}, {15'h0000, irq});
  endtask : flip
  initial
  begin
    ext = 16'h0000;
    sys_rst = 1'b1;
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    sys_rst = 1'b0;
    for (int i = 0; i < 5; i++)
      rdchk(7'(7'h5A + 2 * i), 16'h0000);
    foreach (rows[i])
    begin
      host.wr(rows[i].a, rows[i].w);
      rdchk(rows[i].a, rows[i].r);
    end
    ext = 16'h00F0;
    host.wr(gei_pkg::ADDR_PIN_DATA, 16'hFEA5);
    host.wr(gei_pkg::ADDR_PIN_DIR, 16'h000F);
    repeat (6) @(negedge mclk);
    rdchk(gei_pkg::ADDR_PIN_DATA, 16'h00F5);
    chk("pin_oe_n", 16'h03F0, {6'h00, oe_n});
    chk("pin_out", 16'h02A5, {6'h00, pout});
    host.wr(gei_pkg::ADDR_PIN_DIR, 16'h03FF);
    repeat (6) @(negedge mclk);
    rdchk(gei_pkg::ADDR_PIN_DATA, 16'h02A5);
    host.wr(gei_pkg::ADDR_PIN_DIR, 16'h0000);
    ext = 16'h0000;
    for (int i = 0; i < 16; i++)
    begin
      b = 16'h0001 << i;
      if (i != 10)
      begin
        host.wr(gei_pkg::ADDR_RISE_EN, b);
        flip(b);
        host.wr(gei_pkg::ADDR_IRQ_STATUS, ~b);
        rdchk(gei_pkg::ADDR_IRQ_STATUS, b);
        host.wr(gei_pkg::ADDR_IRQ_STATUS, b);
        flip(16'h0000);
        host.wr(gei_pkg::ADDR_RISE_EN, 16'h0000);
        host.wr(gei_pkg::ADDR_FALL_EN, b);
        flip(16'h0000);
        flip(b);
        host.wr(gei_pkg::ADDR_FALL_EN, 16'h0000);
        host.wr(gei_pkg::ADDR_IRQ_STATUS, b);
      end
    end
    host.wr(gei_pkg::ADDR_PIN_DIR, 16'h03FF);
    sys_rst = 1'b1;
    @(negedge mclk);
    sys_rst = 1'b0;
    chk("pin_oe_n", 16'h03FF, {6'h00, oe_n});
    rdchk(gei_pkg::ADDR_PIN_DIR, 16'h0000);
    stop_test();
  end
endmodule : tb
`default_nettype wire
